// [rtl/lin_ld_regs.svh]
// Constants for the four-channel LIN low-detect and break sequencer.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LIN_LD_REGS_SVH
`define LIN_LD_REGS_SVH
`define NUM_CHANNELS      4
`define BREAK_LOW_BASE    5'h0D
`define DELIM_BASE        3'h1
`define BYTE_BITS         4'hA
`define IBS_BITS_DEFAULT  4'h1
`endif

// [rtl/lin_ld_pkg.sv]
// Types for the LIN low-detect and break sequencer.
// Assumes the constants header sits in the include path.
`default_nettype none
`include "lin_ld_regs.svh"
package lin_ld_pkg;
  typedef struct packed {
    logic [3:0] break_low_len;
    logic       delimiter_len_hi;
    logic       delimiter_len_lo;
    logic [3:0] response_data_len;
  } frame_cfg_t;
  typedef enum logic [2:0] {IDLE, BRK_LOW, BRK_DELIM, DATA_BYTE, IBS, DONE} tx_state_t;
endpackage
`default_nettype wire

// [rtl/lin_low_detect_and_break.sv]
// Four-channel LIN low detection with shared request, plus break and response
// sequencing for one transmitter. Assumes a bit-time tick from the baud timebase.
//
// Notes on behaviour
// - A falling edge on an enabled channel input sets its low-detect flag with a request.
// - Setting the enable while the input is already low also sets the flag with a request.
// - Hardware never clears a flag; software writes 1 to clear, writing 0 has no effect.
// - A four-bit summary reads back the current flag of each channel 0 to 3.
// - The shared low-detect request pulses for one cycle when a flag sets while no summary bit is 1.
// - While any flag is 1, flags of other channels setting raise no new request.
// - Break low length is 13 plus a four-bit field, so 13 to 28 bit times.
// - Break delimiter length is 1 plus a two-bit field, so 1 to 4 bit times.
// - Each response byte is followed by an interbyte space, then the next byte.
// - Byte and space repeat for the programmed data length, then the frame ends.
// - A reception error during a data byte or interbyte space abandons remaining bytes and skips the checksum judgement.
`default_nettype none
`include "lin_ld_regs.svh"
module lin_low_detect_and_break (
  // Clock and reset
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RST_I,
  // Line side
  input  wire logic [3:0]            LIN_RX_I,
  output logic                       LIN_TX_O,
  // Low detect control
  input  wire logic [3:0]            LOW_DETECT_ENABLE_I,
  input  wire logic [3:0]            FLAG_CLEAR_I,
  output logic [3:0]                 SUMMARY_FLAG_O,
  output logic                       LOW_DETECT_IRQ_O,
  // Transmit sequencing
  input  wire logic                  BIT_TICK_I,
  input  wire lin_ld_pkg::frame_cfg_t FRAME_CFG_I,
  input  wire logic                  TX_START_I,
  input  wire logic                  RX_ERROR_I,
  output logic                       TX_BUSY_O,
  output logic                       BYTE_REQ_O,
  output logic                       CHECKSUM_SKIP_O
);
  import lin_ld_pkg::*;

  logic [3:0] rx_meta;
  logic [3:0] rx_sync;
  logic [3:0] rx_prev;
  logic [3:0] enable_prev;
  logic [3:0] flag;
  logic [3:0] set_cond;
  logic [3:0] edge_set;
  logic [3:0] level_set;
  logic [3:0] next_flag;
  logic       any_flag;
  tx_state_t  state;
  logic [4:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic       count_done;
  logic       byte_follows;

  // Shared countdown step for every timed state
  function automatic logic [4:0] count_down(input logic [4:0] value);
    count_down = value - 5'h01;
  endfunction

  // Break low load: fixed base plus the length field, less the final tick
  function automatic logic [4:0] break_low_load(input logic [3:0] field);
    break_low_load = count_down(`BREAK_LOW_BASE + {1'b0, field});
  endfunction

  // Delimiter load: the two field bits directly, since zero also lasts a tick
  function automatic logic [4:0] delim_load(input logic hi, input logic lo);
    delim_load = {3'h0, hi, lo};
  endfunction

  // Data byte load: start, eight data and stop bits, less the final tick
  function automatic logic [4:0] byte_load();
    byte_load = count_down({1'b0, `BYTE_BITS});
  endfunction

  // Interbyte space load; a fixed width chosen at build time
  function automatic logic [4:0] ibs_load();
    ibs_load = count_down({1'b0, `IBS_BITS_DEFAULT});
  endfunction

  // Two-stage synchroniser; only rx_sync and its delayed copy rx_prev feed logic
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      rx_meta <= 4'hF;
      rx_sync <= 4'hF;
      rx_prev <= 4'hF;
    end
    else
    begin
      rx_meta <= LIN_RX_I;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Enable history for rising-enable-while-low detection
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      enable_prev <= 4'h0;
    else
      enable_prev <= LOW_DETECT_ENABLE_I;
  end

  // Falling edge on an enabled channel, seen after synchronisation
  always_comb
  begin
    edge_set = rx_prev & ~rx_sync & LOW_DETECT_ENABLE_I;
  end

  // Enable just raised while the line already sits low; without this a
  // node asleep on a dominant bus would never be flagged
  always_comb
  begin
    level_set = LOW_DETECT_ENABLE_I & ~enable_prev & ~rx_sync;
  end

  // Either cause sets the flag; both at once still count as one event
  always_comb
  begin
    set_cond = edge_set | level_set;
  end

  assign any_flag = |flag;

  // Next flag value, shared by the flags and their summary copy
  assign next_flag = set_cond | (flag & ~FLAG_CLEAR_I);

  // Flags: set wins over a software clear so no event is lost
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      flag <= 4'h0;
    else
      flag <= next_flag;
  end

  // Summary mirrors flags; a copy so the output comes from its own flop
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      SUMMARY_FLAG_O <= 4'h0;
    else
      SUMMARY_FLAG_O <= next_flag;
  end

  // Request pulse only when no flag was already pending
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      LOW_DETECT_IRQ_O <= 1'b0;
    else
      LOW_DETECT_IRQ_O <= (|set_cond) && !any_flag;
  end

  // Last tick of the running countdown
  assign count_done = BIT_TICK_I && (bit_cnt == 5'h00);

  // A data byte follows only while bytes remain to be sent
  always_comb
  begin
    byte_follows = 1'b0;
    if (state == BRK_DELIM)
      byte_follows = (FRAME_CFG_I.response_data_len != 4'h0);
    else if (state == IBS)
      byte_follows = (byte_cnt != 4'h0);
  end

  // Transmit sequencer, timed in bit ticks.
  // Each timed state loads bit_cnt with its length minus one and leaves on
  // the tick that finds it at zero, so a load of n lasts n + 1 ticks.
  // The start pulse is not tied to a tick, so the first break bit may be
  // short by up to one tick period; start on a tick for exact lengths.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      state   <= IDLE;
      bit_cnt <= 5'h00;
    end
    else
    begin
      unique case (state)
        IDLE:
          if (TX_START_I)
          begin
            state   <= BRK_LOW;
            bit_cnt <= break_low_load(FRAME_CFG_I.break_low_len);
          end
        BRK_LOW:
          if (BIT_TICK_I)
          begin
            if (bit_cnt == 5'h00)
            begin
              state   <= BRK_DELIM;
              bit_cnt <= delim_load(FRAME_CFG_I.delimiter_len_hi,
                                    FRAME_CFG_I.delimiter_len_lo);
            end
            else
              bit_cnt <= count_down(bit_cnt);
          end
        BRK_DELIM:
          if (BIT_TICK_I)
          begin
            if (bit_cnt == 5'h00)
            begin
              state   <= byte_follows ? DATA_BYTE : DONE;
              bit_cnt <= byte_load();
            end
            else
              bit_cnt <= count_down(bit_cnt);
          end
        DATA_BYTE:
          if (RX_ERROR_I)
            state <= DONE;
          else if (BIT_TICK_I)
          begin
            if (bit_cnt == 5'h00)
            begin
              state   <= IBS;
              bit_cnt <= ibs_load();
            end
            else
              bit_cnt <= count_down(bit_cnt);
          end
        IBS:
          if (RX_ERROR_I)
            state <= DONE;
          else if (BIT_TICK_I)
          begin
            if (bit_cnt == 5'h00)
            begin
              state   <= byte_follows ? DATA_BYTE : DONE;
              bit_cnt <= byte_load();
            end
            else
              bit_cnt <= count_down(bit_cnt);
          end
        DONE:
          state <= IDLE;
        default:
          state <= IDLE;
      endcase
    end
  end

  // Bytes still owed in this response; loaded as the delimiter ends
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      byte_cnt <= 4'h0;
    else if (state == BRK_DELIM && count_done)
      byte_cnt <= FRAME_CFG_I.response_data_len;
    else if (state == DATA_BYTE && count_done && !RX_ERROR_I)
      byte_cnt <= byte_cnt - 4'h1;
  end

  // Line output: dominant only while the break low runs
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      LIN_TX_O <= 1'b1;
    else
      LIN_TX_O <= (state != BRK_LOW);
  end

  // Busy from the start pulse until the sequencer is idle again
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      TX_BUSY_O <= 1'b0;
    else
      TX_BUSY_O <= (state != IDLE);
  end

  // Byte request only when a data byte really follows, so a zero length
  // or the last space of a response raises none
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      BYTE_REQ_O <= 1'b0;
    else
      BYTE_REQ_O <= count_done && byte_follows && !RX_ERROR_I;
  end

  // Checksum skip holds until the next frame starts
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
      CHECKSUM_SKIP_O <= 1'b0;
    else if (TX_START_I && state == IDLE)
      CHECKSUM_SKIP_O <= 1'b0;
    else if (RX_ERROR_I && (state == DATA_BYTE || state == IBS))
      CHECKSUM_SKIP_O <= 1'b1;
  end
endmodule // lin_low_detect_and_break
`default_nettype wire

// [tb/lin_ld_monitor.sv]
// Checker for flag, request and break timing.
// Assumes bit ticks at least three clock cycles apart.
`default_nettype none
module lin_ld_monitor (
  // Watched ports
  input wire logic [3:0] LIN_RX_I,
  input wire logic [3:0] LOW_DETECT_ENABLE_I,
  input wire logic [3:0] FLAG_CLEAR_I,
  input wire logic [3:0] SUMMARY_FLAG_O,
  input wire lin_ld_pkg::frame_cfg_t FRAME_CFG_I,
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic LIN_TX_O,
  input wire logic LOW_DETECT_IRQ_O,
  input wire logic BIT_TICK_I,
  input wire logic RX_ERROR_I,
  input wire logic TX_BUSY_O,
  input wire logic CHECKSUM_SKIP_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_ticks;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Ticks seen while dominant; cleared on recessive
  always_ff @(posedge CLK_SYS_I)
    if (RST_I || LIN_TX_O) low_ticks <= 5'h00;
    else if (BIT_TICK_I) low_ticks <= low_ticks + 5'h01;
  sequence s_fall2;
    $fell(LIN_RX_I[2]) && LOW_DETECT_ENABLE_I[2];
  endsequence
  a_no_self_clear: assert property (
    !(|($past(SUMMARY_FLAG_O) & ~SUMMARY_FLAG_O & ~$past(FLAG_CLEAR_I)))) else $error("flag lost");
  a_irq_first_only: assert property (
    LOW_DETECT_IRQ_O |-> $past(SUMMARY_FLAG_O) == 4'h0 && SUMMARY_FLAG_O != 4'h0)
    else $error("extra request");
  a_irq_raised: assert property (
    $past(SUMMARY_FLAG_O) == 4'h0 && SUMMARY_FLAG_O != 4'h0 |-> LOW_DETECT_IRQ_O)
    else $error("request missing");
  a_fall_sets: assert property (s_fall2 |-> ##[1:4] SUMMARY_FLAG_O[2])
    else $error("edge not flagged");
  a_set_needs_en: assert property ($rose(SUMMARY_FLAG_O[3]) |-> $past(LOW_DETECT_ENABLE_I[3]))
    else $error("set while disabled");
  a_break_len: assert property (
    $rose(LIN_TX_O) |-> low_ticks == 5'h0D + FRAME_CFG_I.break_low_len) else $error("break len");
  a_low_in_frame: assert property (!LIN_TX_O |-> TX_BUSY_O)
    else $error("low outside frame");
  a_skip_cause: assert property ($rose(CHECKSUM_SKIP_O) |-> $past(RX_ERROR_I))
    else $error("skip without error");
endmodule // lin_ld_monitor
bind lin_low_detect_and_break lin_ld_monitor u_mon (.*);
`default_nettype wire

// [tb/lin_bus_model.sv]
// Transceiver and bus: recessive high unless a node pulls low.
// Assumes channel 0 reads the transmitter back.
`default_nettype none
module lin_bus_model (
  // Line side
  input  wire logic       tx_i,
  input  wire logic [3:0] wake_i,
  output logic      [3:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins unless a wake node drives dominant or, on channel 0, tx_i is low
  assign rx_o = ~wake_i & {3'h7, tx_i};
endmodule // lin_bus_model
`default_nettype wire

// [tb/lin_low_detect_and_break_tb.sv]
// Bench: low detect flags and request, then framed transmit.
// Assumes the checker binds itself.
`default_nettype none
module lin_low_detect_and_break_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lin_ld_pkg::*;
  logic clk = 0, rst = 1, tick = 0, start = 0, err = 0, tx, irq, busy, breq, skip;
  logic [3:0] rx, en = 0, clr = 0, wake = 0, sum;
  frame_cfg_t cfg = '0;
  int fails = 0, checks = 0, irqs = 0, cyc = 0;
  lin_bus_model u_bus (.tx_i(tx), .wake_i(wake), .rx_o(rx));
  lin_low_detect_and_break u_dut (.CLK_SYS_I(clk), .RST_I(rst), .LIN_RX_I(rx), .LIN_TX_O(tx),
    .LOW_DETECT_ENABLE_I(en), .FLAG_CLEAR_I(clr), .SUMMARY_FLAG_O(sum),
    .LOW_DETECT_IRQ_O(irq), .BIT_TICK_I(tick), .FRAME_CFG_I(cfg), .TX_START_I(start),
    .RX_ERROR_I(err), .TX_BUSY_O(busy), .BYTE_REQ_O(breq), .CHECKSUM_SKIP_O(skip));
  always #5 clk = ~clk;
  // Tick every eighth cycle, request count, hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tick <= (cyc % 8 == 7);
    if (irq) irqs <= irqs + 1;
    if (cyc > 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic drive(input logic [3:0] e, w, c, input int n);
    @(posedge clk);
    en <= e;
    wake <= w;
    clr <= c;
    repeat (n) @(negedge clk);
  endtask
  task automatic low_detect();
    drive(4'h7, 4'h4, 4'h0, 6);
    chk({4'h0, sum}, 8'h04);
    chk(irqs[7:0], 8'h01);
    drive(4'h7, 4'h2, 4'h0, 3);
    drive(4'h7, 4'h6, 4'h0, 6);
    chk({4'h0, sum}, 8'h06);
    chk(irqs[7:0], 8'h01);
    drive(4'h7, 4'h0, 4'h2, 1);
    drive(4'h7, 4'h8, 4'h0, 6);
    chk({4'h0, sum}, 8'h04);
    drive(4'h7, 4'h8, 4'h4, 1);
    drive(4'hF, 4'h8, 4'h0, 4);
    chk({4'h0, sum}, 8'h08);
    chk(irqs[7:0], 8'h02);
    drive(4'h0, 4'h0, 4'h8, 2);
  endtask
  task automatic frame(input logic [3:0] b, input logic [1:0] d, input logic [3:0] n, int e);
    int lo = 0, dl = 0, nb = 0, bt = 0, k;
    @(posedge clk iff tick);
    cfg <= '{b, d[1], d[0], n};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 3000 && (k < 2 || busy); k++)
    begin
      @(posedge clk);
      if (e > 0 && nb == e) err <= 1'b1;
      @(negedge clk);
      if (tick && !tx) lo++;
      if (tick && tx && lo > 0 && nb == 0) dl++;
      if (tick && nb > 0) bt++;
      if (breq) nb++;
    end
    @(posedge clk);
    err <= 1'b0;
    chk(lo[7:0], 8'h0D + b);
    chk(dl[7:0], 8'h01 + d);
    chk(nb[7:0], e > 0 ? e[7:0] : {4'h0, n});
    chk({7'h00, skip}, {7'h00, e > 0});
    if (e == 0) chk(bt[7:0], 8'h0B * n);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    low_detect();
    frame(4'h0, 2'h0, 4'h1, 0);
    frame(4'hF, 2'h3, 4'h2, 0);
    frame(4'h7, 2'h1, 4'h0, 0);
    frame(4'h3, 2'h2, 4'h4, 2);
    frame(4'h1, 2'h0, 4'h1, 0);
    report_and_stop();
  end
endmodule // lin_low_detect_and_break_tb
`default_nettype wire
